/* File: verilog/tsf_pkg.sv */
// constants shared by the timer channel status block
package tsf_pkg;
	localparam int NCH = 6; // timer channels
	// ***************************************************
	// register map (byte addresses)
	// ***************************************************
	localparam logic [7:0] OFF_STATUS0  = 8'h00; // channel_status 0..5
	localparam logic [7:0] OFF_ENABLE0  = 8'h20; // irq_enable_reg 0..5
	localparam logic [7:0] OFF_IRQ_STAT = 8'h40; // event summary, rd clr
	localparam logic [7:0] OFF_IRQ_MASK = 8'h44; // event summary mask
	localparam logic [7:0] OFF_LAST     = 8'h14; // last channel offset
	// ***************************************************
	// field positions
	// ***************************************************
	localparam int BIT_DIR = 7; // count_direction_flag
	localparam int BIT_RS6 = 6; // reserved, reads one
	localparam int BIT_UDF = 5; // underflow_flag
	localparam int BIT_OVF = 4; // overflow_flag
	// masks of live flag bits per channel group
	localparam logic [7:0] FLAG_FOUR = 8'h1f; // ch 0 and 3
	localparam logic [7:0] FLAG_TWO  = 8'h33; // ch 1,2,4,5
	// writable enable bits per group
	localparam logic [7:0] IEN_FOUR  = 8'h9f;
	localparam logic [7:0] IEN_TWO   = 8'hb3;
	localparam logic [7:0] IEN_RST   = 8'h40; // bit 6 reads one
	localparam logic [7:0] RSV_ONES  = 8'h40; // reserved bit 6 reads one, other reserved bits read zero
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	// channel groups: 0 and 3 own four general registers
	function automatic logic is_four(input int ch);
		return (ch == 0) || (ch == 3);
	endfunction : is_four
	// true when addr falls in a six-word bank starting at base
	function automatic logic bank_hit(input logic [7:0] a,
					  input logic [7:0] base);
		return (a >= base) && (a <= base + OFF_LAST);
	endfunction : bank_hit
	// word index within a bank
	function automatic logic [2:0] bank_idx(input logic [7:0] a,
						input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		return d[4:2];
	endfunction : bank_idx
endpackage : tsf_pkg

/* File: verilog/tsf_chan_if.sv */
// per-channel bundle between the top and its channel modules
`timescale 1ns/1ps
`default_nettype none
interface tsf_chan_if;
	logic       rd_stb;     // read of this channel_status
	logic       wr_stb;     // write of this channel_status
	logic       ien_wr;     // write of this irq_enable_reg
	logic [7:0] wdata;      // write data, low byte
	logic [7:0] status;     // channel_status read value
	logic [7:0] ien;        // irq_enable_reg read value
	logic       count_up;   // counter direction, 1 = up
	logic       phase_mode; // phase counting mode active
	logic       ovf_evt;    // counter wrapped ffff to 0000
	logic       udf_evt;    // counter wrapped 0000 to ffff
	logic [3:0] cmp_match;  // counter equals general reg d..a
	logic [3:0] cap_stb;    // capture loaded general reg d..a
	logic [3:0] gr_capture; // general reg d..a in capture mode
	logic       evt;        // enabled flag set this cycle
	modport top  (output rd_stb, wr_stb, ien_wr, wdata, count_up,
		      phase_mode, ovf_evt, udf_evt, cmp_match, cap_stb,
		      gr_capture, input status, ien, evt);
	modport stat (input rd_stb, wr_stb, wdata, count_up, phase_mode,
		      ovf_evt, udf_evt, cmp_match, cap_stb, gr_capture, ien,
		      output status, evt);
	modport en   (input ien_wr, wdata, output ien);
endinterface : tsf_chan_if
`default_nettype wire

/* File: verilog/tsf_chan_enable.sv */
// interrupt enable register of one timer channel
`timescale 1ns/1ps
`default_nettype none
module tsf_chan_enable #(
	parameter logic FOUR = 1'b0 // channel owns four general regs
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	tsf_chan_if.en    cif
);
	localparam logic [7:0] WMASK = FOUR ? tsf_pkg::IEN_FOUR
					     : tsf_pkg::IEN_TWO;
	logic [7:0] ien_reg; // enables, reserved bits held constant
	// only live bits take write data; reserved ones keep reset value
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ien_reg <= tsf_pkg::IEN_RST;
		end else if (cif.ien_wr) begin
			ien_reg <= (cif.wdata & WMASK) | tsf_pkg::RSV_ONES;
		end
	end
	assign cif.ien = ien_reg;
endmodule : tsf_chan_enable
`default_nettype wire

/* File: verilog/tsf_chan_status.sv */
// sticky status flags of one timer channel
`timescale 1ns/1ps
`default_nettype none
module tsf_chan_status #(
	parameter logic FOUR = 1'b0 // channel owns four general regs
) (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	tsf_chan_if.stat  cif
);
	localparam logic [7:0] FMASK = FOUR ? tsf_pkg::FLAG_FOUR
					     : tsf_pkg::FLAG_TWO;
	logic [7:0] flag_reg;  // sticky flags
	logic [7:0] armed_reg; // flags seen as one by a read
	logic [7:0] set_vec;   // hardware set conditions
	logic [7:0] clr_vec;   // software clear requests
	logic [3:0] gr_evt;    // general register events d..a
	logic       dir_bit;   // bit 7 read value
	// each general reg flags by its configured function
	assign gr_evt = (cif.gr_capture & cif.cap_stb) |
			(~cif.gr_capture & cif.cmp_match);
	always_comb begin
		set_vec = 8'h00;
		set_vec[3:0] = gr_evt;
		set_vec[tsf_pkg::BIT_OVF] = cif.ovf_evt;
		set_vec[tsf_pkg::BIT_UDF] = cif.udf_evt &
					    cif.phase_mode;
		set_vec = set_vec & FMASK; // reserved bits never set
	end
	// a zero clears only a flag already read as one; ones do nothing
	assign clr_vec = cif.wr_stb ? (~cif.wdata & armed_reg & FMASK)
				    : 8'h00;
	// set beats a clear landing in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= 8'h00;
		end else begin
			flag_reg <= (flag_reg & ~clr_vec) | set_vec;
		end
	end
	// remember which flags a read returned as one
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_reg <= 8'h00;
		end else if (cif.rd_stb) begin
			armed_reg <= (armed_reg & ~clr_vec) | flag_reg;
		end else begin
			armed_reg <= armed_reg & ~clr_vec;
		end
	end
	assign dir_bit = FOUR ? 1'b1 : cif.count_up;
	always_comb begin
		cif.status = flag_reg & FMASK;
		cif.status[tsf_pkg::BIT_DIR] = dir_bit;
		cif.status[tsf_pkg::BIT_RS6] = 1'b1;
	end
	// only enabled flags raise a request event
	assign cif.evt = |(set_vec & cif.ien & FMASK);
endmodule : tsf_chan_status
`default_nettype wire

/* File: verilog/tsf_top.sv */
// six timer channel status registers behind an axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - channels 1,2,4,5 bit 7 shows direction
// - channels 0,3 bit 7 reads one
// - bit 6 always reads one
// - phase mode underflow sets bit 5
// - channels 0,3 bit 5 reads zero
// - counter overflow sets bit 4
// - compare match on d sets bit 3
// - capture into d sets bit 3
// - channels 1,2,4,5 bit 3 reads zero
// - match or capture on c sets bit 2
// - channels 1,2,4,5 bit 2 reads zero
// - match or capture on b sets bit 1
// - match or capture on a sets bit 0
// - clear needs read of one then zero
// - writing one never sets a flag
// - six independent status registers
// - request only while enable bit set
module tsf_top (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// timer side events, same clock, one bit per channel, four per channel for the general reg inputs
	input  wire logic [5:0]  count_up,
	input  wire logic [5:0]  phase_mode,
	input  wire logic [5:0]  ovf_evt,
	input  wire logic [5:0]  udf_evt,
	input  wire logic [23:0] cmp_match,
	input  wire logic [23:0] cap_stb,
	input  wire logic [23:0] gr_capture,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// interrupt
	output logic             irq
);
	// ***************************************************
	// bus state
	// ***************************************************
	logic        awready_reg;  // write address slot free
	logic        wready_reg;   // write data slot free
	logic        bvalid_reg;   // write response pending
	logic [1:0]  bresp_reg;    // write response code
	logic        arready_reg;  // read address slot free
	logic        rvalid_reg;   // read data pending
	logic [1:0]  rresp_reg;    // read response code
	logic [31:0] rdata_reg;    // read data
	logic        rd_pend_reg;  // read accepted, data next edge
	logic [7:0]  awaddr_reg;   // captured write address
	logic [7:0]  wdata_reg;    // captured low data byte
	logic        wlane_reg;    // low byte lane enabled
	logic [7:0]  araddr_reg;   // captured read address
	logic        wr_stb;       // write takes effect this cycle
	logic        rd_stb;       // read takes effect this cycle
	// ***************************************************
	// decode and event summary
	// ***************************************************
	logic        wr_stat_hit;  // write lands in status bank
	logic        wr_en_hit;    // write lands in enable bank
	logic        wr_ok;        // write address is mapped
	logic        rd_stat_hit;  // read lands in status bank
	logic        rd_en_hit;    // read lands in enable bank
	logic        rd_ok;        // read address is mapped
	logic [2:0]  wr_idx;       // channel of write
	logic [2:0]  rd_idx;       // channel of read
	logic [7:0]  rd_byte;      // selected read value
	logic [5:0]  irq_stat_reg; // sticky per-channel events
	logic [5:0]  irq_mask_reg; // per-channel event mask
	logic        irq_reg;      // registered interrupt
	logic [5:0]  chan_evt;     // enabled flag set, per channel
	logic [7:0]  stat_rd [6];  // channel_status values
	logic [7:0]  ien_rd  [6];  // irq_enable_reg values
	tsf_chan_if  cif [6] ();   // channel bundles
	// ***************************************************
	// channel instances
	// ***************************************************
	// one independent status and enable register per channel
	for (genvar c = 0; c < tsf_pkg::NCH; c++) begin : g_ch
		localparam logic FOUR = tsf_pkg::is_four(c);
		// hand the shared strobes to the addressed channel only
		assign cif[c].rd_stb = rd_stb & rd_stat_hit &
				       (rd_idx == 3'(c));
		assign cif[c].wr_stb = wr_stb & wlane_reg & wr_stat_hit &
				       (wr_idx == 3'(c));
		assign cif[c].ien_wr = wr_stb & wlane_reg & wr_en_hit &
				       (wr_idx == 3'(c));
		assign cif[c].wdata      = wdata_reg;
		assign cif[c].count_up   = count_up[c];
		assign cif[c].phase_mode = phase_mode[c];
		assign cif[c].ovf_evt    = ovf_evt[c];
		assign cif[c].udf_evt    = udf_evt[c];
		assign cif[c].cmp_match  = cmp_match[4*c +: 4];
		assign cif[c].cap_stb    = cap_stb[4*c +: 4];
		assign cif[c].gr_capture = gr_capture[4*c +: 4];
		assign stat_rd[c]  = cif[c].status;
		assign ien_rd[c]   = cif[c].ien;
		assign chan_evt[c] = cif[c].evt;
		// sticky flags with read-then-zero clearing
		tsf_chan_status #(
			.FOUR (FOUR)
		) u_stat (
			.sys_clk (sys_clk),
			.rst_n   (rst_n),
			.cif     (cif[c])
		);
		// enable bits that gate the request events
		tsf_chan_enable #(
			.FOUR (FOUR)
		) u_en (
			.sys_clk (sys_clk),
			.rst_n   (rst_n),
			.cif     (cif[c])
		);
	end
	// ***************************************************
	// address decode
	// ***************************************************
	// unaligned addresses, or ones outside both banks, summary and mask, answer decode error
	always_comb begin
		wr_stat_hit = tsf_pkg::bank_hit(awaddr_reg,
						tsf_pkg::OFF_STATUS0) &
			      (awaddr_reg[1:0] == 2'h0);
		wr_en_hit   = tsf_pkg::bank_hit(awaddr_reg,
						tsf_pkg::OFF_ENABLE0) &
			      (awaddr_reg[1:0] == 2'h0);
		wr_idx      = wr_stat_hit ?
			      tsf_pkg::bank_idx(awaddr_reg,
						tsf_pkg::OFF_STATUS0) :
			      tsf_pkg::bank_idx(awaddr_reg,
						tsf_pkg::OFF_ENABLE0);
		wr_ok       = wr_stat_hit | wr_en_hit |
			      (awaddr_reg == tsf_pkg::OFF_IRQ_STAT) |
			      (awaddr_reg == tsf_pkg::OFF_IRQ_MASK);
	end
	always_comb begin
		rd_stat_hit = tsf_pkg::bank_hit(araddr_reg,
						tsf_pkg::OFF_STATUS0) &
			      (araddr_reg[1:0] == 2'h0);
		rd_en_hit   = tsf_pkg::bank_hit(araddr_reg,
						tsf_pkg::OFF_ENABLE0) &
			      (araddr_reg[1:0] == 2'h0);
		rd_idx      = rd_stat_hit ?
			      tsf_pkg::bank_idx(araddr_reg,
						tsf_pkg::OFF_STATUS0) :
			      tsf_pkg::bank_idx(araddr_reg,
						tsf_pkg::OFF_ENABLE0);
		rd_ok       = rd_stat_hit | rd_en_hit |
			      (araddr_reg == tsf_pkg::OFF_IRQ_STAT) |
			      (araddr_reg == tsf_pkg::OFF_IRQ_MASK);
	end
	// read mux, unmapped reads return zero
	always_comb begin
		rd_byte = 8'h00;
		if (rd_stat_hit) begin
			rd_byte = stat_rd[rd_idx];
		end else if (rd_en_hit) begin
			rd_byte = ien_rd[rd_idx];
		end else if (araddr_reg == tsf_pkg::OFF_IRQ_STAT) begin
			rd_byte = {2'h0, irq_stat_reg};
		end else if (araddr_reg == tsf_pkg::OFF_IRQ_MASK) begin
			rd_byte = {2'h0, irq_mask_reg};
		end
	end
	// ***************************************************
	// write channels
	// ***************************************************
	// the write happens once both halves are held and no reply waits
	assign wr_stb = ~awready_reg & ~wready_reg & ~bvalid_reg;
	// address slot: taken on handshake, freed when reply is taken
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_reg <= 1'b1;
			awaddr_reg  <= 8'h00;
		end else if (awready_reg & s_axi_awvalid) begin
			awready_reg <= 1'b0;
			awaddr_reg  <= s_axi_awaddr;
		end else if (bvalid_reg & s_axi_bready) begin
			awready_reg <= 1'b1;
		end
	end
	// data slot: a cleared lane 0 turns the write into a no-op
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wready_reg <= 1'b1;
			wdata_reg  <= 8'h00;
			wlane_reg  <= 1'b0;
		end else if (wready_reg & s_axi_wvalid) begin
			wready_reg <= 1'b0;
			wdata_reg  <= s_axi_wdata[7:0];
			wlane_reg  <= s_axi_wstrb[0];
		end else if (bvalid_reg & s_axi_bready) begin
			wready_reg <= 1'b1;
		end
	end
	// write response, one cycle after both halves are held
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= tsf_pkg::RESP_OKAY;
		end else if (wr_stb) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_ok ? tsf_pkg::RESP_OKAY
					    : tsf_pkg::RESP_DECERR;
		end else if (bvalid_reg & s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end
	// ***************************************************
	// read channels
	// ***************************************************
	// the side effects of a read fire on the cycle the data is latched
	assign rd_stb = rd_pend_reg;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_reg <= 1'b1;
			araddr_reg  <= 8'h00;
			rd_pend_reg <= 1'b0;
		end else if (arready_reg & s_axi_arvalid) begin
			arready_reg <= 1'b0;
			araddr_reg  <= s_axi_araddr;
			rd_pend_reg <= 1'b1;
		end else begin
			rd_pend_reg <= 1'b0;
			if (rvalid_reg & s_axi_rready) begin
				arready_reg <= 1'b1;
			end
		end
	end
	// read data and response, held until rready
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= tsf_pkg::RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (rd_pend_reg) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= rd_ok ? tsf_pkg::RESP_OKAY
					    : tsf_pkg::RESP_DECERR;
			rdata_reg  <= {24'h00_0000, rd_byte};
		end else if (rvalid_reg & s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	// ***************************************************
	// interrupt summary
	// ***************************************************
	// sticky per-channel event bits; a read clears, a new event wins
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= 6'h00;
		end else if (rd_stb &&
			     araddr_reg == tsf_pkg::OFF_IRQ_STAT) begin
			irq_stat_reg <= chan_evt;
		end else begin
			irq_stat_reg <= irq_stat_reg | chan_evt;
		end
	end
	// mask written only when lane 0 is enabled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_reg <= 6'h00;
		end else if (wr_stb && wlane_reg &&
			     awaddr_reg == tsf_pkg::OFF_IRQ_MASK) begin
			irq_mask_reg <= wdata_reg[5:0];
		end
	end
	// registered level output, one cycle behind the summary
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end
	// ***************************************************
	// outputs
	// ***************************************************
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign irq           = irq_reg;
endmodule : tsf_top
`default_nettype wire

/* File: verification/tsf_sva.sv */
// checker for the axi side and status read-back of the timer status block
`timescale 1ns/1ps
`default_nettype none
module tsf_sva (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [5:0]  count_up,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        irq
);
	// ***************************************************
	// helper logic
	// ***************************************************
	logic [7:0] rd_addr_reg; // address of the read in flight
	logic [2:0] rd_ch;       // channel word index of that read
	logic       rd_stat;     // read targets a channel_status word
	logic       rd_four;     // channel owns four general regs
	logic       cu_bit;      // direction input of the read channel
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// keep the address so the returned byte can be decoded later
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_addr_reg <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rd_addr_reg <= s_axi_araddr;
		end
	end
	assign rd_ch   = rd_addr_reg[4:2];
	assign rd_stat = (rd_addr_reg <= 8'h14) && (rd_addr_reg[1:0] == 2'h0);
	assign rd_four = rd_stat && (rd_ch == 3'h0 || rd_ch == 3'h3);
	assign cu_bit  = count_up[rd_ch];
	// map: status and enable banks, summary, mask; aligned only
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= 8'h14 || a == 8'h40 ||
			(a >= 8'h20 && a <= 8'h34) || a == 8'h44);
	endfunction : mapped
	// ***************************************************
	// assertions
	// ***************************************************
	bresp_timing_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	rresp_timing_a: assert property (s_axi_arvalid && s_axi_arready
		|-> !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer timing");
	bhold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	rhold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	wbusy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	decode_a: assert property ($rose(s_axi_rvalid) |->
		(s_axi_rresp == 2'h0) == mapped(rd_addr_reg)) else $error("decode");
	decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |->
		s_axi_rdata == 32'h0) else $error("error read carries data");
	rsv_six_a: assert property (s_axi_rvalid && rd_stat && s_axi_rresp == 2'h0 |->
		s_axi_rdata[6]) else $error("bit 6 low");
	grp_four_a: assert property (s_axi_rvalid && rd_four |->
		s_axi_rdata[7] && !s_axi_rdata[5]) else $error("four group bits");
	grp_two_a: assert property (s_axi_rvalid && rd_stat && !rd_four |->
		s_axi_rdata[3:2] == 2'h0) else $error("two group bits");
	dir_bit_a: assert property ($rose(s_axi_rvalid) && rd_stat && !rd_four |->
		s_axi_rdata[7] == $past(cu_bit)) else $error("direction bit");
	// main scenarios reached
	cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
	cover property ($rose(irq));
endmodule : tsf_sva
`default_nettype wire

/* File: verification/tsf_tb_top.sv */
// self-checking bench for the timer channel status block
`timescale 1ns/1ps
`default_nettype none
module tsf_tb_top;
	// ***************************************************
	// signals and model state
	// ***************************************************
	logic        sys_clk, rst_n, irq;
	logic [5:0]  count_up, phase_mode, ovf_evt, udf_evt;
	logic [23:0] cmp_match, cap_stb, gr_capture;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [7:0]  flg [6]; // expected flags per channel
	logic [7:0]  arm [6]; // flags read as one, clearable
	int          num_errors, check_count;
	tsf_top dut (.sys_clk, .rst_n, .count_up, .phase_mode, .ovf_evt,
		.udf_evt, .cmp_match, .cap_stb, .gr_capture, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
	// 200 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ***************************************************
	// helpers
	// ***************************************************
	function automatic logic [31:0] nx();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction : nx
	// live flag bits: four-register channels have no underflow
	function automatic logic [7:0] lmask(input int c);
		return (c == 0 || c == 3) ? 8'h1f : 8'h33;
	endfunction : lmask
	function automatic logic [7:0] exp_stat(input int c);
		return {(c == 0 || c == 3) ? 1'b1 : count_up[c], 1'b1, flg[c][5:0]};
	endfunction : exp_stat
	task automatic chk(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	// one write; address and data offered together, each dropped when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
			      input logic [3:0] s, output logic [1:0] r);
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		r = 2'h2;
		for (int n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
			      output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		{d, r} = {32'hdead, 2'h2};
		for (int n = 0; n < 100; n++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				{d, r} = {s_axi_rdata, s_axi_rresp};
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask : axi_rd
	// a status read arms every flag it returns as one
	task automatic st_rd(input int c);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(8'(4 * c), d, r);
		chk(d, {24'h0, exp_stat(c)}, "status read");
		arm[c] |= flg[c];
	endtask : st_rd
	// only armed bits written as zero clear; ones never set
	task automatic st_wr(input int w, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		logic [7:0] clr;
		axi_wr(8'(4 * w), d, s, r);
		chk({30'h0, r}, 32'h0, "status write resp");
		clr = s[0] ? (arm[w] & ~d[7:0]) : 8'h00;
		flg[w] &= ~clr;
		arm[w] &= ~clr;
	endtask : st_wr
	// one cycle of events; levels redrawn when rn is set
	task automatic pulse(input logic [5:0] o, input bit rn);
		logic [31:0] r1, r2, r3, r4;
		logic [3:0]  ev;
		r1 = rn ? nx() : 32'h0;
		r2 = rn ? nx() : 32'h0;
		r3 = rn ? nx() : {8'h0, gr_capture};
		r4 = rn ? nx() : 32'h0;
		for (int c = 0; c < 6; c++) begin
			ev = (r3[4*c+:4] & r4[4*c+:4]) | (~r3[4*c+:4] & r2[4*c+:4]);
			flg[c] |= lmask(c) & {2'h0, r1[c] & r1[12+c], o[c], ev};
		end
		@(posedge sys_clk);
		if (rn) begin
			{count_up, phase_mode, gr_capture} <= {r1[11:6], r1[17:12], r3[23:0]};
		end
		{ovf_evt, udf_evt, cmp_match, cap_stb} <= {o, r1[5:0], r2[23:0], r4[23:0]};
		@(posedge sys_clk);
		{ovf_evt, udf_evt, cmp_match, cap_stb} <= 60'h0;
	endtask : pulse
	// hang guard, far beyond the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		$display("wrong value at %0t ns: run timed out", $time);
		close_out();
	end
	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		{rst_n, num_errors, check_count, rnd} = {1'b0, 64'h0, 32'h6660};
		{count_up, phase_mode, ovf_evt, udf_evt} = {6'h2a, 18'h0};
		{cmp_match, cap_stb, gr_capture} = 72'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		for (int c = 0; c < 6; c++) begin
			{flg[c], arm[c]} = 16'h0;
		end
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 6; c++) begin
			st_rd(c);
			axi_rd(8'h20 + 8'(4 * c), d, r);
			chk(d, 32'h40, "enable reset");
		end
		axi_rd(8'h82, d, r);
		chk({d[29:0], r}, 32'h3, "unmapped read");
		axi_wr(8'h50, 32'hff, 4'hf, r);
		chk({30'h0, r}, 32'h3, "unmapped write");
		$display("test reset values done");
		// random events, reads and clears on random channels
		repeat (40) begin
			d = nx();
			pulse(d[5:0], 1'b1);
			st_rd(int'(d[10:8]) % 6);
			d = nx();
			st_wr(int'(d[30:28]) % 6, d, d[11:8]);
		end
		for (int c = 0; c < 6; c++) st_rd(c);
		$display("test random events done");
		// interrupt: overflow of channel 4, masked then unmasked
		axi_wr(8'h44, 32'h0, 4'hf, r);
		axi_wr(8'h30, 32'hff, 4'hf, r);
		axi_rd(8'h30, d, r);
		chk(d, 32'hf3, "enable read back");
		pulse(6'h10, 1'b0);
		repeat (4) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0, "irq masked");
		axi_wr(8'h44, 32'h10, 4'hf, r);
		repeat (4) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h1, "irq raised");
		axi_rd(8'h40, d, r);
		chk(d, 32'h10, "summary");
		repeat (3) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		axi_wr(8'h30, 32'h0, 4'hf, r);
		pulse(6'h10, 1'b0);
		repeat (4) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0, "irq disabled");
		axi_rd(8'h40, d, r);
		chk(d, 32'h0, "summary disabled");
		st_rd(4);
		$display("test interrupt done");
		close_out();
	end
endmodule : tsf_tb_top
bind tsf_top tsf_sva u_sva (.sys_clk, .rst_n, .count_up, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_rready, .irq);
`default_nettype wire
